// *** design/ptcs_top.sv ***
// timestamp clock synchronisation unit with AXI4-Lite register slave
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ptcs_cfg.svh"
module ptcs_top #(
  parameter int CYC_PER_SEC = `PTCS_SEC_NS / `PTCS_CLK_PERIOD_NS,     // cycles per second
  parameter int WIN_TOL_CYC = `PTCS_WIN_TOL_NS / `PTCS_CLK_PERIOD_NS  // pulse window half width
) (
  input  wire logic        aclk,          // 25 MHz clock
  input  wire logic        aresetn,       // synchronous reset, active low
  input  wire logic        ce,            // clock enable, freezes all state when low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        pps_in,        // line pulse-per-second input pin
  output logic             sync_out,      // line sync output level
  output logic             sync_out_en,   // line sync output driven
  output logic             irq            // level interrupt
);
  localparam logic [47:0] ONE_SEC_SUB = 48'(`PTCS_SEC_NS) << `PTCS_FRAC_BITS;
  // step per cycle follows the configured cycles per second, so a shortened second stays whole
  localparam logic [47:0] NOM_INCR    = 48'(`PTCS_SEC_NS / CYC_PER_SEC) << `PTCS_FRAC_BITS;
  localparam logic [25:0] EARLY_CYC   = 26'(CYC_PER_SEC - WIN_TOL_CYC);
  localparam logic [25:0] LATE_CYC    = 26'(CYC_PER_SEC + WIN_TOL_CYC - 1);
  localparam logic [25:0] SEC_CYC     = 26'(CYC_PER_SEC);
  localparam logic [31:0] HALF_NS     = 32'(`PTCS_HALF_SEC_NS);
  localparam logic [31:0] SEC_NS      = 32'(`PTCS_SEC_NS);

  // bus state
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q, next_rdata;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic wr_fire, ar_fire;
  // clock state
  ptcs_pkg::ptcs_in_sel_type in_sel, next_in_sel;
  ptcs_pkg::ptcs_out_sel_type out_sel, next_out_sel;
  ptcs_pkg::ptcs_state_type state, next_state;
  logic [31:0] host_sec, host_ns, thresh, next_host_sec, next_host_ns, next_thresh;
  logic [31:0] loc_sec, next_loc_sec, ns_shadow, next_ns_shadow;
  logic [47:0] loc_sub, next_loc_sub, sub_sum;
  logic signed [31:0] freq_adj, slew, phase_err, next_freq_adj, next_slew, next_phase_err;
  logic [25:0] since_cnt, next_since_cnt;
  logic [15:0] miss_run, longest, next_miss_run, next_longest;
  logic [`PTCS_IRQ_W-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask, irq_set;
  logic [2:0] pps_s;
  logic next_sync_out, next_sync_out_en;
  logic inc_total, inc_bad, inc_single, inc_fail, inc_resync, clr_stats;
  logic [31:0] cnt_total, cnt_bad, cnt_single, cnt_fail, cnt_resync;
  // datapath helpers
  logic [31:0] loc_ns;
  logic signed [47:0] incr_s;
  logic signed [63:0] ref_err, abs_err;
  logic ref_evt, line_edge, master_pulse, sel_pulse, active, early, over;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // write and read channel handshakes and read data mux
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign ar_fire = s_axi_arvalid & ~s_axi_rvalid;
  always_comb begin
    next_aw_held  = (aw_held & ~wr_fire) | s_axi_awvalid & ~aw_held;
    next_w_held   = (w_held & ~wr_fire) | s_axi_wvalid & ~w_held;
    next_awaddr_q = (s_axi_awvalid & ~aw_held) ? s_axi_awaddr : awaddr_q;
    next_wdata_q  = (s_axi_wvalid & ~w_held) ? s_axi_wdata : wdata_q;
    next_wstrb_q  = (s_axi_wvalid & ~w_held) ? s_axi_wstrb : wstrb_q;
    next_bvalid   = wr_fire | (s_axi_bvalid & ~s_axi_bready);
    next_bresp    = s_axi_bresp;
    if (wr_fire) begin
      next_bresp = (awaddr_q[1:0] == 2'h0 && awaddr_q <= `PTCS_A_IRQ_MASK
                    && !(awaddr_q inside {`PTCS_A_STATUS, `PTCS_A_TIME_SEC, `PTCS_A_TIME_NS}
                    || (awaddr_q >= `PTCS_A_PHASE && awaddr_q <= `PTCS_A_LONGEST)))
                   ? 2'h0 : 2'h2;
    end
    next_rvalid = ar_fire | (s_axi_rvalid & ~s_axi_rready);
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (ar_fire) begin
      next_rresp = 2'h0;
      case (s_axi_araddr)
        `PTCS_A_CTRL:     next_rdata = {25'h0, out_sel, 1'b0, in_sel};
        `PTCS_A_CMD:      next_rdata = 32'h0000_0000;
        `PTCS_A_HOST_SEC: next_rdata = host_sec;
        `PTCS_A_HOST_NS:  next_rdata = host_ns;
        `PTCS_A_THRESH:   next_rdata = thresh;
        `PTCS_A_STATUS:   next_rdata = {30'h0, active, state == ptcs_pkg::PTCS_ST_LOCKED};
        `PTCS_A_TIME_SEC: next_rdata = loc_sec;
        `PTCS_A_TIME_NS:  next_rdata = ns_shadow;
        `PTCS_A_PHASE:    next_rdata = phase_err;
        `PTCS_A_FREQ:     next_rdata = freq_adj;
        `PTCS_A_FAILURES: next_rdata = cnt_fail;
        `PTCS_A_RESYNCS:  next_rdata = cnt_resync;
        `PTCS_A_TOTAL:    next_rdata = cnt_total;
        `PTCS_A_BAD:      next_rdata = cnt_bad;
        `PTCS_A_SINGLES:  next_rdata = cnt_single;
        `PTCS_A_LONGEST:  next_rdata = {16'h0, longest};
        `PTCS_A_IRQ_STAT: next_rdata = {28'h0, irq_stat};
        `PTCS_A_IRQ_MASK: next_rdata = {28'h0, irq_mask};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'h2;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (ce) begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      awaddr_q     <= next_awaddr_q;
      wdata_q      <= next_wdata_q;
      wstrb_q      <= next_wstrb_q;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // time datapath: increment, pulse edge, error against reference
  assign loc_ns       = loc_sub[47:16];
  assign incr_s       = $signed(NOM_INCR) + 48'(freq_adj) + 48'(slew);
  assign sub_sum      = loc_sub + $unsigned(incr_s);
  assign line_edge    = pps_s[1] & ~pps_s[2];
  assign active       = state != ptcs_pkg::PTCS_ST_IDLE;
  assign master_pulse = loc_ns < `PTCS_MASTER_WIDTH_NS;
  assign sel_pulse    = (in_sel == ptcs_pkg::PTCS_IN_LINE) ? pps_s[1] :
                        (in_sel == ptcs_pkg::PTCS_IN_INTERNAL) ? master_pulse : 1'b0;
  assign early        = active && (in_sel == ptcs_pkg::PTCS_IN_LINE) && (since_cnt < EARLY_CYC);
  assign irq          = |(irq_stat & irq_mask);
  always_comb begin
    ref_evt = 1'b0;
    ref_err = 64'sh0;
    case (in_sel)
      ptcs_pkg::PTCS_IN_LINE: begin
        ref_evt = line_edge;
        ref_err = (loc_ns < HALF_NS) ? -$signed({32'h0, loc_ns}) : $signed({32'h0, SEC_NS - loc_ns});
      end
      ptcs_pkg::PTCS_IN_INTERNAL: begin
        ref_evt = wr_fire && awaddr_q == `PTCS_A_CMD && wstrb_q[0] && wdata_q[`PTCS_CMD_HOSTREF];
        ref_err = 64'($signed({1'b0, host_sec}) - $signed({1'b0, loc_sec})) * 64'sd1000000000
                  + $signed({32'h0, host_ns}) - $signed({32'h0, loc_ns});
      end
      default: ref_evt = 1'b0;
    endcase
    abs_err = ref_err[63] ? -ref_err : ref_err;
    over    = abs_err > $signed({32'h0, thresh});
  end

  // clock, discipline, statistics and register next values
  always_comb begin
    next_in_sel = in_sel;     next_out_sel = out_sel;   next_state = state;
    next_host_sec = host_sec; next_host_ns = host_ns;   next_thresh = thresh;
    next_loc_sec = loc_sec;   next_loc_sub = loc_sub;   next_ns_shadow = ns_shadow;
    next_freq_adj = freq_adj; next_slew = slew;         next_phase_err = phase_err;
    next_since_cnt = since_cnt; next_miss_run = miss_run; next_longest = longest;
    next_irq_mask = irq_mask; irq_set = '0;
    inc_total = 1'b0; inc_bad = 1'b0; inc_single = 1'b0; inc_fail = 1'b0; inc_resync = 1'b0;
    clr_stats = 1'b0;
    // free-running advance on the local oscillator
    if (sub_sum >= ONE_SEC_SUB) begin
      next_loc_sub = sub_sum - ONE_SEC_SUB;
      next_loc_sec = loc_sec + 32'h0000_0001;
    end else begin
      next_loc_sub = sub_sum;
    end
    if (ar_fire && s_axi_araddr == `PTCS_A_TIME_SEC) begin
      next_ns_shadow = loc_ns;
    end
    if (ref_evt && early) begin
      inc_bad = 1'b1;
      irq_set[`PTCS_IRQ_BAD] = 1'b1;
    end else if (ref_evt) begin
      inc_total = 1'b1;
      inc_single = (miss_run == 16'h0001);
      next_longest = (miss_run > longest) ? miss_run : longest;
      next_since_cnt = 26'h0;
      next_miss_run = 16'h0;
      next_phase_err = ref_err[31:0];
      if (over) begin
        // phase too far out: step the counter onto the reference
        inc_resync = 1'b1;
        inc_fail = (state == ptcs_pkg::PTCS_ST_LOCKED);
        irq_set[`PTCS_IRQ_LOST] = (state == ptcs_pkg::PTCS_ST_LOCKED);
        next_slew = 32'sh0;
        next_state = ptcs_pkg::PTCS_ST_ACQUIRE;
        if (in_sel == ptcs_pkg::PTCS_IN_LINE) begin
          next_loc_sec = (loc_ns >= HALF_NS) ? loc_sec + 32'h0000_0001 : loc_sec;
          next_loc_sub = NOM_INCR; // pulse is second zero, this edge is already one step past it
        end else begin
          next_loc_sec = host_sec;
          next_loc_sub = {host_ns, 16'h0000};
        end
      end else begin
        // within threshold: trim frequency, slew out phase over the next second
        next_freq_adj = freq_adj + ($signed(ref_err[31:0]) >>> `PTCS_FREQ_SHIFT);
        next_slew = $signed(ref_err[31:0]) >>> `PTCS_SLEW_SHIFT;
        irq_set[`PTCS_IRQ_LOCK] = (state != ptcs_pkg::PTCS_ST_LOCKED);
        next_state = ptcs_pkg::PTCS_ST_LOCKED;
      end
    end else if (active && since_cnt >= LATE_CYC) begin
      // window passed with no pulse: one more missed second
      next_since_cnt = since_cnt - SEC_CYC;
      next_miss_run = miss_run + 16'h0001;
      next_slew = 32'sh0;
      irq_set[`PTCS_IRQ_MISS] = 1'b1;
      if (miss_run + 16'h0001 >= `PTCS_LOST_LIMIT) begin
        next_state = ptcs_pkg::PTCS_ST_IDLE;
        inc_fail = (state == ptcs_pkg::PTCS_ST_LOCKED);
        irq_set[`PTCS_IRQ_LOST] = (state == ptcs_pkg::PTCS_ST_LOCKED);
      end
    end else if (active) begin
      next_since_cnt = since_cnt + 26'h1;
    end
    if (in_sel != ptcs_pkg::PTCS_IN_LINE && in_sel != ptcs_pkg::PTCS_IN_INTERNAL) begin
      next_state = ptcs_pkg::PTCS_ST_IDLE;
      next_slew = 32'sh0;
    end
    // register writes and commands override the datapath
    if (wr_fire) begin
      case (awaddr_q)
        `PTCS_A_CTRL: begin
          if (wstrb_q[0]) begin
            next_in_sel  = ptcs_pkg::ptcs_in_sel_type'(wdata_q[`PTCS_CTRL_IN_LSB +: 3]);
            next_out_sel = ptcs_pkg::ptcs_out_sel_type'(wdata_q[`PTCS_CTRL_OUT_LSB +: 3]);
          end
        end
        `PTCS_A_CMD: begin
          if (wstrb_q[0] && (wdata_q[`PTCS_CMD_SET] || wdata_q[`PTCS_CMD_RESET])) begin
            next_loc_sec = host_sec;
            next_loc_sub = {host_ns, 16'h0000};
          end
          if (wstrb_q[0] && wdata_q[`PTCS_CMD_RESET]) begin
            next_in_sel   = ptcs_pkg::PTCS_IN_LINE;
            next_out_sel  = ptcs_pkg::PTCS_OUT_NONE;
            next_state    = ptcs_pkg::PTCS_ST_IDLE;
            next_freq_adj = 32'sh0;
            next_slew     = 32'sh0;
          end
          if (wstrb_q[0] && wdata_q[`PTCS_CMD_CLRSTATS]) begin
            clr_stats    = 1'b1;
            next_longest = 16'h0;
          end
        end
        `PTCS_A_HOST_SEC: next_host_sec = merge(host_sec, wdata_q, wstrb_q);
        `PTCS_A_HOST_NS:  next_host_ns  = merge(host_ns, wdata_q, wstrb_q);
        `PTCS_A_THRESH:   next_thresh   = merge(thresh, wdata_q, wstrb_q);
        `PTCS_A_IRQ_MASK: next_irq_mask = wstrb_q[0] ? wdata_q[`PTCS_IRQ_W-1:0] : irq_mask;
        default: next_thresh = thresh;
      endcase
    end
    // sticky events, write one to clear, a new event wins over the clear
    next_irq_stat = irq_stat | irq_set;
    if (wr_fire && awaddr_q == `PTCS_A_IRQ_STAT && wstrb_q[0]) begin
      next_irq_stat = (irq_stat & ~wdata_q[`PTCS_IRQ_W-1:0]) | irq_set;
    end
    // output selector
    case (out_sel)
      ptcs_pkg::PTCS_OUT_REPEAT: next_sync_out = pps_s[1];
      ptcs_pkg::PTCS_OUT_LOOP:   next_sync_out = sel_pulse;
      ptcs_pkg::PTCS_OUT_MASTER: next_sync_out = master_pulse;
      default:                   next_sync_out = 1'b0;
    endcase
    next_sync_out_en = out_sel inside {ptcs_pkg::PTCS_OUT_REPEAT, ptcs_pkg::PTCS_OUT_LOOP,
                                       ptcs_pkg::PTCS_OUT_MASTER};
  end

  // clock-side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sel <= ptcs_pkg::PTCS_IN_LINE;
      out_sel <= ptcs_pkg::PTCS_OUT_NONE;
      state <= ptcs_pkg::PTCS_ST_IDLE;
      host_sec <= 32'h0000_0000; host_ns <= 32'h0000_0000; thresh <= `PTCS_THRESH_RST;
      loc_sec <= 32'h0000_0000; loc_sub <= 48'h0; ns_shadow <= 32'h0000_0000;
      freq_adj <= 32'sh0; slew <= 32'sh0; phase_err <= 32'sh0;
      since_cnt <= 26'h0; miss_run <= 16'h0; longest <= 16'h0;
      irq_stat <= '0; irq_mask <= '0; pps_s <= 3'h0;
      sync_out <= 1'b0; sync_out_en <= 1'b0;
    end else if (ce) begin
      in_sel <= next_in_sel; out_sel <= next_out_sel; state <= next_state;
      host_sec <= next_host_sec; host_ns <= next_host_ns; thresh <= next_thresh;
      loc_sec <= next_loc_sec; loc_sub <= next_loc_sub; ns_shadow <= next_ns_shadow;
      freq_adj <= next_freq_adj; slew <= next_slew; phase_err <= next_phase_err;
      since_cnt <= next_since_cnt; miss_run <= next_miss_run; longest <= next_longest;
      irq_stat <= next_irq_stat; irq_mask <= next_irq_mask;
      pps_s <= {pps_s[1:0], pps_in}; // two-flop synchroniser plus edge stage
      sync_out <= next_sync_out; sync_out_en <= next_sync_out_en;
    end
  end

  // statistics counters
  ptcs_stat_counter u_total  (.aclk(aclk), .aresetn(aresetn), .ce(ce), .clr(clr_stats),
                              .inc(inc_total), .count(cnt_total));
  ptcs_stat_counter u_bad    (.aclk(aclk), .aresetn(aresetn), .ce(ce), .clr(clr_stats),
                              .inc(inc_bad), .count(cnt_bad));
  ptcs_stat_counter u_single (.aclk(aclk), .aresetn(aresetn), .ce(ce), .clr(clr_stats),
                              .inc(inc_single), .count(cnt_single));
  ptcs_stat_counter u_fail   (.aclk(aclk), .aresetn(aresetn), .ce(ce), .clr(clr_stats),
                              .inc(inc_fail), .count(cnt_fail));
  ptcs_stat_counter u_resync (.aclk(aclk), .aresetn(aresetn), .ce(ce), .clr(clr_stats),
                              .inc(inc_resync), .count(cnt_resync));
endmodule : ptcs_top
`default_nettype wire

// *** design/ptcs_cfg.svh ***
// offsets, field positions, reset values and timing figures of the timestamp sync unit
`ifndef PTCS_CFG_SVH
`define PTCS_CFG_SVH
// timing
`define PTCS_CLK_PERIOD_NS   40
`define PTCS_SEC_NS          1000000000
`define PTCS_HALF_SEC_NS     500000000
`define PTCS_WIN_TOL_NS      1000000
`define PTCS_MASTER_WIDTH_NS 32'h05F5_E100
`define PTCS_FRAC_BITS       16
`define PTCS_LOST_LIMIT      16'h0003
`define PTCS_SLEW_SHIFT      9
`define PTCS_FREQ_SHIFT      10
// reset values
`define PTCS_THRESH_RST      32'h0000_0254
// register byte offsets
`define PTCS_A_CTRL      8'h00
`define PTCS_A_CMD       8'h04
`define PTCS_A_HOST_SEC  8'h08
`define PTCS_A_HOST_NS   8'h0C
`define PTCS_A_THRESH    8'h10
`define PTCS_A_STATUS    8'h14
`define PTCS_A_TIME_SEC  8'h18
`define PTCS_A_TIME_NS   8'h1C
`define PTCS_A_PHASE     8'h20
`define PTCS_A_FREQ      8'h24
`define PTCS_A_FAILURES  8'h28
`define PTCS_A_RESYNCS   8'h2C
`define PTCS_A_TOTAL     8'h30
`define PTCS_A_BAD       8'h34
`define PTCS_A_SINGLES   8'h38
`define PTCS_A_LONGEST   8'h3C
`define PTCS_A_IRQ_STAT  8'h40
`define PTCS_A_IRQ_MASK  8'h44
// field positions
`define PTCS_CTRL_IN_LSB   0
`define PTCS_CTRL_OUT_LSB  4
`define PTCS_CMD_SET       0
`define PTCS_CMD_RESET     1
`define PTCS_CMD_CLRSTATS  2
`define PTCS_CMD_HOSTREF   3
`define PTCS_IRQ_LOCK      0
`define PTCS_IRQ_LOST      1
`define PTCS_IRQ_BAD       2
`define PTCS_IRQ_MISS      3
`define PTCS_IRQ_W         4
`endif

// *** design/ptcs_pkg.sv ***
// types of the timestamp sync unit
package ptcs_pkg;
  typedef enum logic [2:0] {
    PTCS_IN_NONE     = 3'h0,
    PTCS_IN_LINE     = 3'h1,
    PTCS_IN_HOST     = 3'h2,
    PTCS_IN_INTERNAL = 3'h3,
    PTCS_IN_AUX      = 3'h4
  } ptcs_in_sel_type;
  typedef enum logic [2:0] {
    PTCS_OUT_NONE   = 3'h0,
    PTCS_OUT_REPEAT = 3'h1,
    PTCS_OUT_LOOP   = 3'h2,
    PTCS_OUT_HOST   = 3'h3,
    PTCS_OUT_MASTER = 3'h4
  } ptcs_out_sel_type;
  typedef enum logic [1:0] {
    PTCS_ST_IDLE    = 2'b00,
    PTCS_ST_ACQUIRE = 2'b01,
    PTCS_ST_LOCKED  = 2'b11
  } ptcs_state_type;
endpackage : ptcs_pkg

// *** design/ptcs_stat_counter.sv ***
// saturating 32-bit statistics counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module ptcs_stat_counter (
  input  wire logic        aclk,    // system clock
  input  wire logic        aresetn, // synchronous reset, active low
  input  wire logic        ce,      // clock enable
  input  wire logic        clr,     // clear to zero
  input  wire logic        inc,     // count one event
  output logic      [31:0] count    // current count
);
  logic [31:0] next_count;

  // clear beats increment, count stops at all ones
  always_comb begin
    next_count = count;
    if (clr) begin
      next_count = 32'h0000_0000;
    end else if (inc && (count != 32'hFFFF_FFFF)) begin
      next_count = count + 32'h0000_0001;
    end
  end

  // register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h0000_0000;
    end else if (ce) begin
      count <= next_count;
    end
  end
endmodule : ptcs_stat_counter
`default_nettype wire

// *** tb/ptcs_pps_src.sv ***
// behavioural pulse-per-second source standing on the line input
`timescale 1ns/1ps
`default_nettype none
module ptcs_pps_src #(
  parameter int PERIOD = 1000 // cycles between pulses
) (
  input  wire logic aclk, // bench clock
  input  wire logic run,  // emit pulses when high
  input  wire logic kick, // stray pulse out of window
  output var  logic pps   // pulse line, idles low
);
  int cnt = 0;
  initial pps = 1'b0;
  // ten cycle pulse once per period; line rests low between pulses
  always @(posedge aclk) begin
    cnt <= (!run || cnt == PERIOD - 1) ? 0 : cnt + 1;
    pps <= (run && cnt < 10) || kick;
  end
endmodule : ptcs_pps_src
`default_nettype wire

// *** tb/ptcs_top_chk.sv ***
// bus handshake and sync output checker for the timestamp sync unit
`timescale 1ns/1ps
`default_nettype none
module ptcs_top_chk (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset, active low
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arready, // ar ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic [1:0]  s_axi_rresp,   // read response
  input wire logic        sync_out,      // sync level
  input wire logic        sync_out_en,   // sync driven
  input wire logic        irq            // interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");
  a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("bad read response code");
  a_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> !sync_out_en && !irq)
    else $error("outputs active after reset");
  c_irq: cover property (irq);
  c_sync: cover property ($rose(sync_out));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : ptcs_top_chk
bind ptcs_top ptcs_top_chk u_chk (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the timestamp sync unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, run = 0, kick = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d, h, t;
  logic [1:0] rr, wb;
  wire logic awr, wrdy, bv, arr, rv, pps, so, soe, irq;
  wire logic [1:0] br, rresp;
  wire logic [31:0] rdata;
  int err_count = 0, n_tests = 0, cyc = 0, k;
  always #20 aclk = ~aclk;
  ptcs_top #(.CYC_PER_SEC(1000), .WIN_TOL_CYC(50)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .pps_in(pps), .sync_out(so), .sync_out_en(soe), .irq(irq));
  ptcs_pps_src #(.PERIOD(1000)) u_src (.aclk(aclk), .run(run), .kick(kick), .pps(pps));
  // expected control word and output drive
  function automatic logic [31:0] ctrl_val(input int i, input int o);
    return {25'h0, o[2:0], 1'b0, i[2:0]};
  endfunction : ctrl_val
  function automatic logic [31:0] en_exp(input int o);
    return {31'h0, o == 1 || o == 2 || o == 4};
  endfunction : en_exp
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  // write: address and data offered together, readiness sampled before each edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw, gb;
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(negedge aclk); ga = awr; gw = wrdy; gb = bv; wb = br;
      @(posedge aclk); if (ga) awv <= 0; if (gw) wv <= 0;
    end while (!gb);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic g, v;
    @(posedge aclk);
    ara <= a; arv <= 1; rready <= 1;
    do begin
      @(negedge aclk); g = arr; v = rv; rd_d = rdata; rr = rresp;
      @(posedge aclk); if (g) arv <= 0;
    end while (!v);
    rready <= 0;
  endtask : rd
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin err_count++; end_sim(); end
  end
  initial begin
    void'($urandom(32'hB325A83A));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00); chk(rd_d, ctrl_val(1, 0));
    rd(8'h10); chk(rd_d, 32'h0000_0254);
    rd(8'h48); chk(rd_d, 32'h0); chk({30'h0, rr}, 32'h2);
    t = $urandom; wr(8'h10, t); rd(8'h10); chk(rd_d, t);
    wr(8'h18, t); chk({30'h0, wb}, 32'h2);
    wr(8'h10, 32'h0000_0254); chk({30'h0, wb}, 32'h0);
    // every input and output selection, drive enable follows the output choice
    for (int i = 0; i < 5; i++) for (int o = 0; o < 5; o++) begin
      wr(8'h00, ctrl_val(i, o)); rd(8'h00);
      chk(rd_d, ctrl_val(i, o));
      chk({31'h0, soe}, en_exp(o));
    end
    k = 0; wr(8'h00, ctrl_val(0, 4));
    repeat (2000) begin @(negedge aclk); k += (so === 1'b1); end
    chk(k, 200);
    h = $urandom_range(32'h7FFF_0000); wr(8'h08, h); wr(8'h0C, 0);
    wr(8'h00, ctrl_val(3, 2)); wr(8'h04, 32'h1);
    rd(8'h18); chk(rd_d, h);
    rd(8'h00); chk(rd_d, ctrl_val(3, 2));
    repeat (1500) @(posedge aclk);
    rd(8'h18); chk(rd_d, h + 1);
    wr(8'h04, 32'h8); rd(8'h18); chk(rd_d, h);
    wr(8'h04, 32'h2); rd(8'h00); chk(rd_d, ctrl_val(1, 0));
    rd(8'h18); chk(rd_d, h);
    // pulses on the line input, lock and interrupt
    wr(8'h04, 32'h4); wr(8'h00, ctrl_val(1, 1)); wr(8'h44, 32'hF); wr(8'h40, 32'hF);
    run <= 1;
    k = 0; repeat (6500) begin @(negedge aclk); k += (so === 1'b1); end
    chk(k, 70);
    rd(8'h14); chk(rd_d & 32'h3, 32'h3);
    chk({31'h0, irq}, 32'h1);
    rd(8'h40); chk(rd_d & 32'h1, 32'h1);
    wr(8'h44, 32'h0); chk({31'h0, irq}, 32'h0);
    wr(8'h40, 32'h1); rd(8'h40); chk(rd_d & 32'h1, 32'h0);
    kick <= 1; repeat (10) @(posedge aclk); kick <= 0;
    repeat (10) @(posedge aclk);
    rd(8'h34); chk(rd_d, 32'h1);
    run <= 0; repeat (4000) @(posedge aclk);
    rd(8'h14); chk(rd_d & 32'h2, 32'h0);
    rd(8'h30); chk(rd_d, 32'h7);
    wr(8'h04, 32'h4); rd(8'h34); chk(rd_d, 32'h0);
    rd(8'h30); chk(rd_d, 32'h0);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
